// ==== core/cpp_pkg.sv ====
/*
  Constants and types for the charger power-path control block.
  Assumes a single 250 MHz clock; analog comparators arrive as clean levels.
*/
`default_nettype none
package cpp_pkg;
  localparam int unsigned CLK_PERIOD_NS = 4;
  // Safety timer: 6 hours, counted in slow ticks
  localparam int unsigned SAFETY_HOURS = 6;
  localparam int unsigned TICK_NS = 1000000;
  localparam longint unsigned SAFETY_NS = 64'(SAFETY_HOURS) * 64'h0000_0346_30b8_a000;
  localparam int unsigned TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;
  localparam int unsigned SAFETY_TICKS = int'(SAFETY_NS / 64'(TICK_NS));
  // Short-circuit retest deglitch time
  localparam int unsigned SHORT_DEGLITCH_NS = 250000;
  localparam int unsigned SHORT_DEGLITCH_CYCLES = SHORT_DEGLITCH_NS / CLK_PERIOD_NS;
  // USB limit codes, sel2 sel1 sel0
  localparam logic [2:0] USB_100MA = 3'h0;
  localparam logic [2:0] USB_500MA = 3'h1;
  localparam logic [2:0] USB_1500MA = 3'h2;
  localparam logic [2:0] USB_SUSPEND = 3'h3;
  localparam logic [2:0] USB_150MA = 3'h4;
  localparam logic [2:0] USB_900MA = 3'h5;
  localparam logic [2:0] USB_800MA = 3'h6;
  localparam logic [2:0] USB_HIZ = 3'h7;
  // Input current limit in mA
  localparam logic [11:0] IN_LIMIT_RESISTOR_PIN_100 = 12'h064;
  localparam logic [11:0] IN_LIMIT_RESISTOR_PIN_150 = 12'h096;
  localparam logic [11:0] IN_LIMIT_RESISTOR_PIN_500 = 12'h1f4;
  localparam logic [11:0] IN_LIMIT_RESISTOR_PIN_800 = 12'h320;
  localparam logic [11:0] IN_LIMIT_RESISTOR_PIN_900 = 12'h384;
  localparam logic [11:0] IN_LIMIT_RESISTOR_PIN_1500 = 12'h5dc;
  localparam logic [11:0] IN_LIMIT_RESISTOR_PIN_NONE = 12'h000;
  // Sag threshold in mV, zero means none
  localparam logic [12:0] SAG_LOW_MV = 13'h10b8;
  localparam logic [12:0] SAG_HIGH_MV = 13'h1158;
  localparam logic [12:0] SAG_NONE_MV = 13'h0000;
  localparam logic [12:0] VREG_REDUCED_MV = 13'h0fdc;
  // Parameter-select codes {a,b}
  localparam logic [1:0] PSEL_NORMAL = 2'h0;
  localparam logic [1:0] PSEL_HALF_I = 2'h1;
  localparam logic [1:0] PSEL_LOW_V = 2'h2;
  localparam logic [1:0] PSEL_SUSPEND = 2'h3;
  typedef enum logic [1:0] {CPP_SRC_NONE, CPP_SRC_IN, CPP_SRC_USB} cpp_src_t;
  typedef enum logic [2:0] {CPP_IDLE, CPP_CHARGE, CPP_DONE, CPP_FAULT, CPP_SUSP}
    cpp_chg_t;
endpackage
`default_nettype wire

// ==== core/cpp_usb_decode.sv ====
/*
  Decoder for the three USB limit-select pins and the two parameter pins.
  Assumes the pins are static levels synchronous to the clock.
*/
`default_nettype none
module cpp_usb_decode import cpp_pkg::*; (
  input wire logic [2:0] usb_sel_i,
  input wire logic [1:0] param_sel_i,
  output logic [11:0] in_limit_resistor_pin_ma_o,
  output logic [12:0] sag_mv_o,
  output logic usb_suspend_o,
  output logic hiz_o,
  output logic low_limit_o,
  output logic half_current_o,
  output logic low_vreg_o,
  output logic charge_suspend_o
);
  always_comb begin
    in_limit_resistor_pin_ma_o = IN_LIMIT_RESISTOR_PIN_NONE;
    sag_mv_o = SAG_HIGH_MV;
    case (usb_sel_i)
      USB_100MA: begin
        in_limit_resistor_pin_ma_o = IN_LIMIT_RESISTOR_PIN_100;
        sag_mv_o = SAG_LOW_MV;
      end
      USB_500MA: in_limit_resistor_pin_ma_o = IN_LIMIT_RESISTOR_PIN_500;
      USB_1500MA: in_limit_resistor_pin_ma_o = IN_LIMIT_RESISTOR_PIN_1500;
      USB_150MA: begin
        in_limit_resistor_pin_ma_o = IN_LIMIT_RESISTOR_PIN_150;
        sag_mv_o = SAG_LOW_MV;
      end
      USB_900MA: in_limit_resistor_pin_ma_o = IN_LIMIT_RESISTOR_PIN_900;
      USB_800MA: in_limit_resistor_pin_ma_o = IN_LIMIT_RESISTOR_PIN_800;
      default: sag_mv_o = SAG_NONE_MV;
    endcase
  end
  assign usb_suspend_o = (usb_sel_i == USB_SUSPEND);
  assign hiz_o = (usb_sel_i == USB_HIZ);
  assign low_limit_o = (usb_sel_i == USB_100MA);
  assign half_current_o = (param_sel_i == PSEL_HALF_I);
  assign low_vreg_o = (param_sel_i == PSEL_LOW_V);
  assign charge_suspend_o = (param_sel_i == PSEL_SUSPEND);
endmodule // cpp_usb_decode
`default_nettype wire

// ==== core/cpp_control.sv ====
/*
  Power-path and charge control for a dual-input single-cell charger.
  Assumes analog comparator results and loop flags are clean synchronous levels.
*/
`default_nettype none
// Function
// - Supply present and enabled starts buck; charge enabled starts charge cycle.
// - Battery above 3.5V turns battery FET fully on.
// - System at minimum level makes power-path loop lower charge current.
// - Zero charge current with rising load enters supplement, FET on.
// - Battery above setpoint turns FET off, system to FET-off level.
// - Battery 5% over setpoint stops converter, FET on to discharge.
// - Decode USB limit pins into current limits, suspend, high impedance.
// - Sag threshold 4.28V for 100/150mA, 4.44V others, none otherwise.
// - All USB pins high: high impedance, buck kept off.
// - 100mA code disables charge termination.
// - Both inputs valid: use higher-power input, paths always isolated.
// - Charge from valid input; over-voltage preferred input uses USB.
// - Battery only: FET on; short trips FET off for deglitch, retest.
// - Discharge gate on with no valid input or high impedance.
// - Six hour timer from charge start; expiry ends charge, FET off, fault.
// - Timer fault cleared only by new cycle via pins, hi-Z, power.
// - Timer half speed under load, sag, thermal regulation, short battery.
// - Timer resets on new cycle and on every thermal shutdown.
// - Driver regulator off below lockout, within sleep margin, thermal shutdown.
// - Parameter pins: normal, half current, 4.06V, charging suspended.
// - Charge suspend by parameter pins keeps buck running.
module cpp_control import cpp_pkg::*; (
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic device_enable_i,
  input wire logic charge_enable_i,
  input wire logic in_valid_i,
  input wire logic in_ovp_i,
  input wire logic usb_valid_i,
  input wire logic usb_ovp_i,
  input wire logic supply_above_uvlo_i,
  input wire logic supply_above_sleep_i,
  input wire logic thermal_shutdown_i,
  input wire logic thermal_reg_i,
  input wire logic input_sag_reg_i,
  input wire logic bat_above_3v5_i,
  input wire logic bat_above_reg_i,
  input wire logic bat_above_ovp_i,
  input wire logic bat_below_short_i,
  input wire logic sys_at_min_i,
  input wire logic charge_current_zero_i,
  input wire logic bat_short_limit_i,
  input wire logic charge_done_i,
  input wire logic usb_limit_sel0_i,
  input wire logic usb_limit_sel1_i,
  input wire logic usb_limit_sel2_i,
  input wire logic param_select_a_i,
  input wire logic param_select_b_i,
  output logic buck_enable_o,
  output logic charge_active_o,
  output logic bat_fet_on_o,
  output logic sys_fetoff_reg_o,
  output logic reduce_charge_o,
  output logic supplement_o,
  output logic sel_in_path_o,
  output logic sel_usb_path_o,
  output logic ext_discharge_gate_o,
  output logic driver_ldo_enable_o,
  output logic termination_enable_o,
  output logic half_current_o,
  output logic low_vreg_o,
  output logic [11:0] usb_in_limit_resistor_pin_ma_o,
  output logic [12:0] input_sag_threshold_o,
  output logic timer_fault_o
);
  typedef struct packed {
    cpp_chg_t chg;
    cpp_src_t src;
    logic [31:0] tick_cnt;
    logic [31:0] safety_cnt;
    logic half_phase;
    logic [31:0] short_cnt;
    logic short_off;
    logic fault;
    logic [2:0] usb_sel_q;
    logic [1:0] psel_q;
    logic ce_q;
    logic power_q;
    logic bfet;
    logic buck;
    logic gate;
    logic ldo;
  } cpp_state_t;

  cpp_state_t st, next_st;
  logic [2:0] usb_sel;
  logic [1:0] psel;
  logic [11:0] in_limit_resistor_pin;
  logic [12:0] sag;
  logic usb_susp, hiz, low_limit, half_i, low_v, chg_susp;
  logic supply_ok, power_up, hiz_toggle, ce_toggle, new_cycle, slow;
  logic in_ok, usb_ok, tick, expire;

  assign usb_sel = {usb_limit_sel2_i, usb_limit_sel1_i, usb_limit_sel0_i};
  assign psel = {param_select_a_i, param_select_b_i};

  cpp_usb_decode u_dec (
    .usb_sel_i(usb_sel),
    .param_sel_i(psel),
    .in_limit_resistor_pin_ma_o(in_limit_resistor_pin),
    .sag_mv_o(sag),
    .usb_suspend_o(usb_susp),
    .hiz_o(hiz),
    .low_limit_o(low_limit),
    .half_current_o(half_i),
    .low_vreg_o(low_v),
    .charge_suspend_o(chg_susp)
  );

  assign in_ok = in_valid_i && !in_ovp_i;
  assign usb_ok = usb_valid_i && !usb_ovp_i && !usb_susp;
  assign supply_ok = in_ok || usb_ok;
  assign power_up = supply_ok && !st.power_q;
  assign hiz_toggle = (st.usb_sel_q == USB_HIZ) != hiz;
  assign ce_toggle = (charge_enable_i != st.ce_q) || (psel != st.psel_q);
  // the only ways a new cycle begins
  assign new_cycle = power_up || hiz_toggle || ce_toggle;
  assign slow = sys_at_min_i || input_sag_reg_i || thermal_reg_i || bat_below_short_i;
  assign tick = (st.tick_cnt == 32'(TICK_CYCLES - 1));
  assign expire = (st.chg == CPP_CHARGE) && (st.safety_cnt >= 32'(SAFETY_TICKS)) &&
                  !(charge_done_i && !low_limit);

  always_comb begin
    next_st = st;
    next_st.usb_sel_q = usb_sel;
    next_st.psel_q = psel;
    next_st.ce_q = charge_enable_i;
    next_st.power_q = supply_ok;
    // IN has precedence, one path at a time
    // fall back to USB when IN is bad
    if (hiz || !device_enable_i) begin
      next_st.src = CPP_SRC_NONE;
    end else if (in_ok) begin
      next_st.src = CPP_SRC_IN;
    end else if (usb_ok) begin
      next_st.src = CPP_SRC_USB;
    end else begin
      next_st.src = CPP_SRC_NONE;
    end
    // buck runs on a present supply
    next_st.buck = supply_ok && device_enable_i && !hiz && !thermal_shutdown_i &&
                   !bat_above_ovp_i;
    next_st.tick_cnt = tick ? 32'h0 : st.tick_cnt + 32'h1;
    case (st.chg)
      CPP_IDLE: begin
        if (next_st.buck && charge_enable_i && !chg_susp) begin
          next_st.chg = CPP_CHARGE;
          next_st.safety_cnt = 32'h0;
          next_st.half_phase = 1'b0;
        end
      end
      CPP_CHARGE: begin
        if (tick) begin
          next_st.half_phase = !st.half_phase;
          if (!slow || st.half_phase) begin
            next_st.safety_cnt = st.safety_cnt + 32'h1;
          end
        end
        if (charge_done_i && !low_limit) begin
          next_st.chg = CPP_DONE;
        end else if (st.safety_cnt >= 32'(SAFETY_TICKS)) begin
          next_st.chg = CPP_FAULT;
          next_st.fault = 1'b1;
        end else if (chg_susp || !charge_enable_i || !next_st.buck) begin
          next_st.chg = chg_susp ? CPP_SUSP : CPP_IDLE;
        end
      end
      CPP_SUSP: begin
        if (!chg_susp) begin
          next_st.chg = CPP_IDLE;
        end
      end
      default: ;
    endcase
    // new cycle clears fault
    // Expiry in the same cycle wins over the clear
    if (new_cycle && !expire) begin
      next_st.fault = 1'b0;
    end
    // new cycle or thermal shutdown resets timer
    if (new_cycle || thermal_shutdown_i) begin
      next_st.safety_cnt = 32'h0;
      next_st.half_phase = 1'b0;
      // Pending fault keeps charging stopped
      next_st.chg = next_st.fault ? CPP_FAULT : CPP_IDLE;
    end
    if (st.short_off) begin
      if (st.short_cnt == 32'(SHORT_DEGLITCH_CYCLES - 1)) begin
        next_st.short_off = 1'b0;
        next_st.short_cnt = 32'h0;
      end else begin
        next_st.short_cnt = st.short_cnt + 32'h1;
      end
    end else if (!supply_ok && bat_short_limit_i) begin
      next_st.short_off = 1'b1;
      next_st.short_cnt = 32'h0;
    end
    if (!supply_ok) begin
      next_st.bfet = !next_st.short_off;
    end else if (bat_above_ovp_i) begin
      next_st.bfet = 1'b1;
    end else if (bat_above_reg_i || next_st.chg == CPP_FAULT) begin
      next_st.bfet = 1'b0;
    end else begin
      next_st.bfet = bat_above_3v5_i || (sys_at_min_i && charge_current_zero_i);
    end
    next_st.gate = !supply_ok || hiz;
    next_st.ldo = supply_above_uvlo_i && supply_above_sleep_i && !thermal_shutdown_i;
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      st <= '{chg: CPP_IDLE, src: CPP_SRC_NONE, default: '0};
    end else begin
      st <= next_st;
    end
  end

  assign buck_enable_o = st.buck;
  assign charge_active_o = (st.chg == CPP_CHARGE);
  assign bat_fet_on_o = st.bfet;
  assign sys_fetoff_reg_o = bat_above_reg_i && !bat_above_ovp_i;
  assign reduce_charge_o = sys_at_min_i;
  assign supplement_o = sys_at_min_i && charge_current_zero_i && st.bfet;
  assign sel_in_path_o = (st.src == CPP_SRC_IN);
  assign sel_usb_path_o = (st.src == CPP_SRC_USB);
  assign ext_discharge_gate_o = st.gate;
  assign driver_ldo_enable_o = st.ldo;
  assign termination_enable_o = !low_limit;
  assign half_current_o = half_i;
  assign low_vreg_o = low_v;
  assign usb_in_limit_resistor_pin_ma_o = in_limit_resistor_pin;
  assign input_sag_threshold_o = sag;
  assign timer_fault_o = st.fault;

  a_path_isolated: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    !(sel_in_path_o && sel_usb_path_o)) else $error("both paths on");
  a_in_precedence: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    (in_ok && usb_ok && device_enable_i && !hiz) |=> sel_in_path_o) else $error("in not used");
  a_usb_fallback: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    (usb_ok && !in_ok && device_enable_i && !hiz) |=> sel_usb_path_o) else $error("usb not used");
  a_hiz_buck_off: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    hiz |=> !buck_enable_o) else $error("buck on in hiz");
  a_gate_no_supply: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    (!supply_ok || hiz) |=> ext_discharge_gate_o) else $error("gate off");
  a_ldo_tsd: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    thermal_shutdown_i |=> !driver_ldo_enable_o) else $error("ldo on");
  a_fault_fet_off: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    (st.chg == CPP_FAULT && supply_ok && !bat_above_ovp_i && !new_cycle)
    |=> !bat_fet_on_o) else $error("fet on in fault");
  a_fault_set_wins: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    expire |=> timer_fault_o) else $error("expiry without fault");
  a_fault_clear: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    (timer_fault_o && !new_cycle) |=> timer_fault_o) else $error("fault lost");
  a_tsd_timer: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    thermal_shutdown_i |=> st.safety_cnt == 32'h0) else $error("timer kept");
  a_timer_hold: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    (st.chg == CPP_CHARGE && !tick && !new_cycle && !thermal_shutdown_i)
    |=> $stable(st.safety_cnt)) else $error("timer moved without tick");
  a_half_speed: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    (st.chg == CPP_CHARGE && tick && slow && !st.half_phase && !new_cycle &&
    !thermal_shutdown_i) |=> $stable(st.safety_cnt)) else $error("timer at full speed");
  a_ovp_fet_on: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    (bat_above_ovp_i && supply_ok) |=> (bat_fet_on_o && !buck_enable_o))
    else $error("bat ovp");
  a_supplement_fet: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    (supply_ok && sys_at_min_i && charge_current_zero_i && !bat_above_reg_i &&
    !bat_above_ovp_i && !timer_fault_o && !expire) |=> bat_fet_on_o) else $error("no supplement");
  a_short_trip: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    (!st.short_off && !supply_ok && bat_short_limit_i) |=> !bat_fet_on_o) else $error("no trip");
  a_short_retest: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    (st.short_off && !supply_ok && st.short_cnt == 32'(SHORT_DEGLITCH_CYCLES - 1))
    |=> bat_fet_on_o) else $error("no retest");
  a_term_low: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    (charge_active_o && low_limit && !new_cycle && !thermal_shutdown_i)
    |=> st.chg != CPP_DONE) else $error("terminated");
  c_charge: cover property (@(posedge clock_i) st.chg == CPP_CHARGE);
  c_done: cover property (@(posedge clock_i) st.chg == CPP_DONE);
  c_fault: cover property (@(posedge clock_i) timer_fault_o);
  c_short: cover property (@(posedge clock_i) st.short_off);
  c_usb: cover property (@(posedge clock_i) sel_usb_path_o);
endmodule // cpp_control
`default_nettype wire

// ==== bench/cpp_host_gpio.sv ====
/*
  Host model: general-purpose outputs that drive the limit and parameter pins.
  Assumes the bench calls its tasks; pins change only at the falling clock edge.
*/
`default_nettype none
module cpp_host_gpio (
  input wire logic clock_i,
  output logic usb_limit_sel0_o,
  output logic usb_limit_sel1_o,
  output logic usb_limit_sel2_o,
  output logic param_select_a_o,
  output logic param_select_b_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] usb_q = 3'h1;
  logic [1:0] par_q = 2'h0;
  assign {usb_limit_sel2_o, usb_limit_sel1_o, usb_limit_sel0_o} = usb_q;
  assign {param_select_a_o, param_select_b_o} = par_q;
  task automatic set_usb(input logic [2:0] c);
    @(negedge clock_i);
    usb_q = c;
  endtask
  task automatic set_par(input logic [1:0] c);
    @(negedge clock_i);
    par_q = c;
  endtask
endmodule // cpp_host_gpio
`default_nettype wire

// ==== bench/charger_power_path_control_test.sv ====
/*
  Self-checking bench for the power-path control block.
  Assumes the host model drives the select pins; comparator inputs are driven here.
*/
`default_nettype none
module charger_power_path_control_test import cpp_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic dev_en = 0, chg_en = 0, in_ok = 0, in_ov = 0, usb_ok = 0, usb_ov = 0;
  logic uv_ok = 0, slp_ok = 0, tsd = 0, treg = 0, sag = 0, b35 = 0, breg = 0;
  logic bovp = 0, bsh = 0, smin = 0, izero = 0, blim = 0, done = 0;
  logic s0, s1, s2, pa, pb;
  logic buck, chg, fet, fetoff, red, supp, pin, pusb, gate, ldo, term, half, lowv, flt;
  logic [11:0] in_limit_resistor_pin;
  logic [12:0] sagv;
  int err_total = 0;
  int tests_run = 0;
  logic [11:0] in_limit_resistor_pin_x[8] = '{IN_LIMIT_RESISTOR_PIN_100, IN_LIMIT_RESISTOR_PIN_500, IN_LIMIT_RESISTOR_PIN_1500, IN_LIMIT_RESISTOR_PIN_NONE,
                             IN_LIMIT_RESISTOR_PIN_150, IN_LIMIT_RESISTOR_PIN_900, IN_LIMIT_RESISTOR_PIN_800, IN_LIMIT_RESISTOR_PIN_NONE};
  logic [12:0] sag_x[8] = '{SAG_LOW_MV, SAG_HIGH_MV, SAG_HIGH_MV, SAG_NONE_MV,
                            SAG_LOW_MV, SAG_HIGH_MV, SAG_HIGH_MV, SAG_NONE_MV};

  initial begin
    forever #2 clk = ~clk;
  end

  cpp_host_gpio host (.clock_i(clk), .usb_limit_sel0_o(s0), .usb_limit_sel1_o(s1),
    .usb_limit_sel2_o(s2), .param_select_a_o(pa), .param_select_b_o(pb));

  cpp_control dut (.clock_i(clk), .sys_rst_i(rst), .device_enable_i(dev_en),
    .charge_enable_i(chg_en), .in_valid_i(in_ok), .in_ovp_i(in_ov), .usb_valid_i(usb_ok),
    .usb_ovp_i(usb_ov), .supply_above_uvlo_i(uv_ok), .supply_above_sleep_i(slp_ok),
    .thermal_shutdown_i(tsd), .thermal_reg_i(treg), .input_sag_reg_i(sag),
    .bat_above_3v5_i(b35), .bat_above_reg_i(breg), .bat_above_ovp_i(bovp),
    .bat_below_short_i(bsh), .sys_at_min_i(smin), .charge_current_zero_i(izero),
    .bat_short_limit_i(blim), .charge_done_i(done), .usb_limit_sel0_i(s0),
    .usb_limit_sel1_i(s1), .usb_limit_sel2_i(s2), .param_select_a_i(pa),
    .param_select_b_i(pb), .buck_enable_o(buck), .charge_active_o(chg),
    .bat_fet_on_o(fet), .sys_fetoff_reg_o(fetoff), .reduce_charge_o(red),
    .supplement_o(supp), .sel_in_path_o(pin), .sel_usb_path_o(pusb),
    .ext_discharge_gate_o(gate), .driver_ldo_enable_o(ldo), .termination_enable_o(term),
    .half_current_o(half), .low_vreg_o(lowv), .usb_in_limit_resistor_pin_ma_o(in_limit_resistor_pin),
    .input_sag_threshold_o(sagv), .timer_fault_o(flt));

  task automatic settle(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic chk(input logic [12:0] got, input logic [12:0] exp, input string m);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t %s", $time, m);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Deglitch retest alone needs about 62500 cycles
  initial begin
    #400000;
    err_total++;
    report_and_stop();
  end

  initial begin
    settle(3);
    rst = 0;
    dev_en = 1; chg_en = 1; usb_ok = 1; uv_ok = 1; slp_ok = 1;
    settle(4);
    chk(buck, 1, "buck not started");
    chk(chg, 1, "charge not started");
    chk({pin, pusb, gate, ldo}, 4'h5, "usb path, gate or ldo");
    in_ok = 1;
    settle(4);
    chk({pin, pusb}, 2'h2, "higher power input not chosen");
    in_ov = 1;
    settle(4);
    chk({pin, pusb}, 2'h1, "overvoltage input not isolated");
    in_ok = 0; in_ov = 0;
    $display("test supply done");
    for (int i = 0; i < 8; i++) begin
      host.set_usb(3'(i));
      settle(4);
      chk(13'(in_limit_resistor_pin), 13'(in_limit_resistor_pin_x[i]), "usb current limit");
      chk(sagv, sag_x[i], "sag threshold");
      chk(13'(term), 13'(i != 0), "termination enable");
      if (i == 7) begin
        chk({buck, gate}, 2'h1, "high impedance mode");
      end
    end
    host.set_usb(3'h1);
    settle(4);
    chk(gate, 0, "gate left on after high impedance");
    $display("test usb codes done");
    for (int i = 0; i < 4; i++) begin
      host.set_par(2'(i));
      settle(4);
      chk({half, lowv}, {1'(i == 1), 1'(i == 2)}, "parameter decode");
      chk({buck, chg}, {1'b1, 1'(i != 3)}, "suspend must keep buck");
    end
    host.set_par(2'h0);
    $display("test parameter codes done");
    host.set_usb(3'h0);
    done = 1;
    settle(4);
    chk(chg, 1, "terminated on lowest code");
    host.set_usb(3'h1);
    settle(4);
    chk(chg, 0, "charge not terminated");
    done = 0;
    $display("test termination done");
    b35 = 1;
    settle(4);
    chk(fet, 1, "fet off above 3.5V");
    breg = 1;
    settle(4);
    chk({fet, fetoff}, 2'h1, "above setpoint handling");
    bovp = 1;
    settle(4);
    chk({buck, fet, fetoff}, 3'h2, "battery overvoltage");
    breg = 0; bovp = 0; b35 = 0; smin = 1;
    settle(4);
    chk({red, supp, fet}, 3'h4, "charge current not reduced");
    izero = 1;
    settle(4);
    chk({supp, fet}, 2'h3, "supplement not entered");
    smin = 0; izero = 0;
    $display("test battery loops done");
    uv_ok = 0;
    settle(4);
    chk(ldo, 0, "ldo on below lockout");
    uv_ok = 1; slp_ok = 0;
    settle(4);
    chk(ldo, 0, "ldo on within sleep margin");
    slp_ok = 1; tsd = 1;
    settle(4);
    chk({ldo, buck}, 2'h0, "thermal shutdown");
    tsd = 0;
    settle(4);
    chk({ldo, flt}, 2'h2, "ldo back, no fault");
    $display("test driver regulator done");
    usb_ok = 0;
    settle(4);
    chk({buck, fet, gate}, 3'h3, "battery only");
    blim = 1;
    settle(4);
    chk(fet, 0, "short not tripped");
    blim = 0;
    settle(SHORT_DEGLITCH_CYCLES + 100);
    chk(fet, 1, "no retest after deglitch");
    $display("test battery only done");
    report_and_stop();
  end
endmodule // charger_power_path_control_test
`default_nettype wire
